// ---- core/pmirc_pkg.sv ----
// ============================================================
// Contract
// [R1] back pressure enable acts only while the port runs half duplex
// [R2] bad frames dropped; pass-all forwards them toward mirroring only
// [R3] pass-all leaves flow-control frame filtering to its own switch-level control
// [R4] bit 6 set gives one port limit, clear gives per-priority limits
// [R5] bit 5 set counts packets, clear counts bits
// [R6] bit 4 set asserts flow control when receive rate is exceeded
// [R7] rate flow control needs port flow control enabled (MAC or PHY pause)
// [R8] bits 3:2 pick counted frames: all, bc/mc/flood, bc/mc, bc only
// [R9] count-gap bit adds 12 bytes per frame to counted size
// [R10] count-preamble bit adds 8 bytes per frame to counted size
// [R11] preamble setting has no effect while packet counting is selected
// [R12] priority 0-6 limits stay pending until priority 7 limit is written
// [R13] MAC receive flow control enable, off by default, gates non-PHY flow control
// [R14] credit buckets refilled at limit rate; excess dropped or flow controlled
package pmirc_pkg;
   // ============================================================
   // register offsets within the port switch MAC block
   localparam logic [7:0] OFF_MAC_CTRL1 = 8'h01;
   localparam logic [7:0] OFF_RATE_CTRL = 8'h03;
   localparam logic [7:0] OFF_PRIO0_LIM = 8'h10;
   localparam logic [7:0] OFF_PRIO7_LIM = 8'h17;
   // ============================================================
   // field positions and reset values
   localparam int BIT_PASS_ALL = 0;
   localparam int BIT_BP_EN = 3;
   localparam int BIT_CNT_PRE = 0;
   localparam int BIT_CNT_IFG = 1;
   localparam int BIT_MODE_LO = 2;
   localparam int BIT_FC_EN = 4;
   localparam int BIT_PPS = 5;
   localparam int BIT_PORT_BASED = 6;
   localparam logic [7:0] MAC_CTRL1_WMASK = 8'hbf;
   localparam logic [7:0] RATE_CTRL_WMASK = 8'h7f;
   localparam logic [7:0] LIM_WMASK = 8'h7f;
   localparam logic [7:0] MAC_CTRL1_RST = 8'h00;
   localparam logic [7:0] RATE_CTRL_RST = 8'h00;
   localparam logic [6:0] LIM_RST = 7'h00;
   // ============================================================
   // frame class codes and per-frame byte additions
   localparam logic [1:0] MODE_ALL = 2'h0;
   localparam logic [1:0] MODE_BMF = 2'h1;
   localparam logic [1:0] MODE_BM = 2'h2;
   localparam logic [1:0] MODE_B = 2'h3;
   localparam logic [13:0] IFG_BYTES = 14'h00c;
   localparam logic [13:0] PRE_BYTES = 14'h008;
   // ============================================================
   // refill timing at 50 MHz
   localparam int CLK_NS = 20;
   localparam int BIT_TICK_NS = 1000;
   localparam int BIT_TICK_CYC = BIT_TICK_NS / CLK_NS;
   localparam int PPS_TICK_US = 520;
   localparam int PPS_TICK_CYC = PPS_TICK_US * 1000 / CLK_NS;
   localparam logic [19:0] CREDIT_CAP = 20'h20000;
   localparam logic [19:0] CREDIT_RST = 20'h00000;
   // ============================================================
   // carriers
   typedef struct packed {
      logic [13:0] len;
      logic [2:0] prio;
      logic crc_err;
      logic len_err;
      logic is_bcast;
      logic is_mcast;
      logic is_flood;
      logic is_fc_frame;
   } pmirc_frame_s;
   typedef struct packed {
      logic fwd;
      logic mirror_only;
      logic drop;
      logic over_limit;
   } pmirc_verdict_s;
endpackage

// ---- core/pmirc_port.sv ----
`timescale 1ns/10ps
module pmirc_port #(
   parameter int PPS_TICK_CYCLES = pmirc_pkg::PPS_TICK_CYC
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic frame_valid_in,
   input wire pmirc_pkg::pmirc_frame_s frame_in,
   output logic verdict_valid_out,
   output pmirc_pkg::pmirc_verdict_s verdict_out,
   input wire logic full_duplex_in,
   input wire logic phy_port_in,
   input wire logic mac_rx_fc_en_in,
   input wire logic phy_pause_adv_in,
   input wire logic fc_frame_filter_in,
   input wire logic fabric_congested_in,
   output logic pause_req_out,
   output logic backpressure_out
);
   // ============================================================
   // registers
   logic [7:0] mac_ctrl1_q;
   logic [7:0] rate_ctrl_q;
   logic [6:0] lim_shadow_q [8];
   logic [6:0] lim_active_q [8];
   logic [19:0] credit_q [8];
   logic [15:0] bit_cnt_q;
   logic [31:0] pps_cnt_q;
   logic fc_active_q;
   pmirc_pkg::pmirc_verdict_s verdict_d;
   logic pass_all, bp_en, port_based, pps_mode, rl_fc_en, cnt_ifg, cnt_pre;
   logic [1:0] lim_mode;
   logic counted, bad, unlimited, exceed, fc_gate, fc_use, refill, admit_debit;
   logic [2:0] idx;
   logic [17:0] cost;
   logic [13:0] bytes;

   assign pass_all = mac_ctrl1_q[pmirc_pkg::BIT_PASS_ALL];
   assign bp_en = mac_ctrl1_q[pmirc_pkg::BIT_BP_EN];
   assign port_based = rate_ctrl_q[pmirc_pkg::BIT_PORT_BASED];
   assign pps_mode = rate_ctrl_q[pmirc_pkg::BIT_PPS];
   assign rl_fc_en = rate_ctrl_q[pmirc_pkg::BIT_FC_EN];
   assign cnt_ifg = rate_ctrl_q[pmirc_pkg::BIT_CNT_IFG];
   assign cnt_pre = rate_ctrl_q[pmirc_pkg::BIT_CNT_PRE];
   assign lim_mode = rate_ctrl_q[pmirc_pkg::BIT_MODE_LO +: 2];

   // ============================================================
   // register writes
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         mac_ctrl1_q <= pmirc_pkg::MAC_CTRL1_RST;
         rate_ctrl_q <= pmirc_pkg::RATE_CTRL_RST;
      end
      else if (reg_wr_in && reg_addr_in == pmirc_pkg::OFF_MAC_CTRL1)
         mac_ctrl1_q <= reg_wdata_in & pmirc_pkg::MAC_CTRL1_WMASK;
      else if (reg_wr_in && reg_addr_in == pmirc_pkg::OFF_RATE_CTRL)
         rate_ctrl_q <= reg_wdata_in & pmirc_pkg::RATE_CTRL_WMASK;
   end

   // read data, registered, unmapped reads zero
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
         reg_rdata_out <= 8'h00;
      else if (reg_addr_in == pmirc_pkg::OFF_MAC_CTRL1)
         reg_rdata_out <= mac_ctrl1_q;
      else if (reg_addr_in == pmirc_pkg::OFF_RATE_CTRL)
         reg_rdata_out <= rate_ctrl_q;
      else if (reg_addr_in >= pmirc_pkg::OFF_PRIO0_LIM && reg_addr_in <= pmirc_pkg::OFF_PRIO7_LIM)
         reg_rdata_out <= {1'b0, lim_shadow_q[reg_addr_in[2:0]]};
      else
         reg_rdata_out <= 8'h00;
   end

   // ============================================================
   // refill tick counters
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in || bit_cnt_q == 16'(pmirc_pkg::BIT_TICK_CYC - 1))
         bit_cnt_q <= 16'h0000;
      else
         bit_cnt_q <= bit_cnt_q + 16'h0001;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in || pps_cnt_q == 32'(PPS_TICK_CYCLES - 1))
         pps_cnt_q <= 32'h00000000;
      else
         pps_cnt_q <= pps_cnt_q + 32'h00000001;
   end

   // packet mode refills slowly, bit mode every microsecond
   assign refill = pps_mode ? (pps_cnt_q == 32'(PPS_TICK_CYCLES - 1)) :
      (bit_cnt_q == 16'(pmirc_pkg::BIT_TICK_CYC - 1)); // R5

   // ============================================================
   // frame classification and cost
   always_comb
   begin
      case (lim_mode) // R8
         pmirc_pkg::MODE_ALL: counted = 1'b1;
         pmirc_pkg::MODE_BMF: counted = frame_in.is_bcast | frame_in.is_mcast | frame_in.is_flood;
         pmirc_pkg::MODE_BM: counted = frame_in.is_bcast | frame_in.is_mcast;
         default: counted = frame_in.is_bcast;
      endcase
   end

   assign idx = port_based ? 3'h0 : frame_in.prio; // R4
   assign bytes = frame_in.len + (cnt_ifg ? pmirc_pkg::IFG_BYTES : 14'h000) // R9
      + ((cnt_pre && !pps_mode) ? pmirc_pkg::PRE_BYTES : 14'h000); // R10 R11
   assign cost = pps_mode ? 18'h00001 : {1'b0, bytes, 3'b000}; // R5
   assign bad = frame_in.crc_err | frame_in.len_err;
   assign unlimited = (lim_active_q[idx] == 7'h00);
   assign exceed = counted && !unlimited && (credit_q[idx] < 20'(cost)); // R14
   assign fc_gate = phy_port_in ? phy_pause_adv_in : mac_rx_fc_en_in; // R7 R13
   assign fc_use = rl_fc_en && fc_gate; // R6 R7

   // ============================================================
   // verdict
   always_comb
   begin
      verdict_d = '0;
      verdict_d.over_limit = exceed;
      if (frame_in.is_fc_frame && fc_frame_filter_in)
         verdict_d.drop = 1'b1; // R3
      else if (bad)
      begin
         verdict_d.mirror_only = pass_all; // R2
         verdict_d.drop = !pass_all; // R2
      end
      else if (exceed && !fc_use)
         verdict_d.drop = 1'b1; // R14
      else
         verdict_d.fwd = 1'b1;
   end

   assign admit_debit = frame_valid_in && verdict_d.fwd && counted && !unlimited;

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         verdict_valid_out <= 1'b0;
         verdict_out <= '0;
      end
      else
      begin
         verdict_valid_out <= frame_valid_in;
         verdict_out <= frame_valid_in ? verdict_d : '0;
      end
   end

   // ============================================================
   // limit shadows and per-bucket credit
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_bucket
         always_ff @(posedge mclk_in)
         begin
            if (!reset_n_in)
               lim_shadow_q[g] <= pmirc_pkg::LIM_RST;
            else if (reg_wr_in && reg_addr_in == pmirc_pkg::OFF_PRIO0_LIM + 8'(g))
               lim_shadow_q[g] <= reg_wdata_in[6:0] & pmirc_pkg::LIM_WMASK[6:0];
         end

         // all limits go live together on the priority 7 write
         always_ff @(posedge mclk_in)
         begin
            if (!reset_n_in)
               lim_active_q[g] <= pmirc_pkg::LIM_RST;
            else if (reg_wr_in && reg_addr_in == pmirc_pkg::OFF_PRIO7_LIM)
               lim_active_q[g] <= (g == 7) ? reg_wdata_in[6:0] : lim_shadow_q[g]; // R12
         end

         // saturating refill ahead of the debit
         logic [20:0] sum;
         logic [19:0] after;
         always_comb
         begin
            sum = {1'b0, credit_q[g]} + (refill ? 21'(lim_active_q[g]) : 21'h0);
            after = (sum > 21'(pmirc_pkg::CREDIT_CAP)) ? pmirc_pkg::CREDIT_CAP : sum[19:0];
         end

         // bucket update, debit floors at zero
         always_ff @(posedge mclk_in)
         begin
            if (!reset_n_in)
               credit_q[g] <= pmirc_pkg::CREDIT_RST;
            else if (admit_debit && idx == 3'(g))
               credit_q[g] <= (after > 20'(cost)) ? after - 20'(cost) : 20'h00000; // R14
            else
               credit_q[g] <= after;
         end
      end
   endgenerate

   // ============================================================
   // flow control toward the link partner
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
         fc_active_q <= 1'b0;
      else if (frame_valid_in && exceed && fc_use && verdict_d.fwd)
         fc_active_q <= 1'b1; // R6
      else if (refill || !fc_use)
         fc_active_q <= 1'b0;
   end

   assign pause_req_out = fc_active_q && full_duplex_in; // R6
   assign backpressure_out = bp_en && !full_duplex_in && (fc_active_q || fabric_congested_in); // R1

   // ============================================================
   // checks
   property p_bad_drop;
      @(posedge mclk_in) disable iff (!reset_n_in)
      frame_valid_in && bad && !pass_all && !frame_in.is_fc_frame |=>
         verdict_valid_out && verdict_out.drop && !verdict_out.fwd;
   endproperty
   a_bad_drop: assert property (p_bad_drop) else $error("bad frame not dropped"); // R2

   property p_bad_mirror;
      @(posedge mclk_in) disable iff (!reset_n_in)
      frame_valid_in && bad && pass_all && !frame_in.is_fc_frame |=>
         verdict_out.mirror_only && !verdict_out.fwd && !verdict_out.drop;
   endproperty
   a_bad_mirror: assert property (p_bad_mirror) else $error("bad frame not mirror only"); // R2

   property p_fc_filter;
      @(posedge mclk_in) disable iff (!reset_n_in)
      frame_valid_in && frame_in.is_fc_frame && fc_frame_filter_in |=> verdict_out.drop;
   endproperty
   a_fc_filter: assert property (p_fc_filter) else $error("fc frame filter bypassed"); // R3

   property p_bp_half;
      @(posedge mclk_in) disable iff (!reset_n_in)
      backpressure_out |-> !full_duplex_in && mac_ctrl1_q[pmirc_pkg::BIT_BP_EN];
   endproperty
   a_bp_half: assert property (p_bp_half) else $error("back pressure in full duplex"); // R1

   property p_fc_gate;
      @(posedge mclk_in) disable iff (!reset_n_in)
      $rose(fc_active_q) |-> $past(rl_fc_en) && $past(fc_gate);
   endproperty
   a_fc_gate: assert property (p_fc_gate) else $error("flow control without enable"); // R7

   property p_pending;
      @(posedge mclk_in) disable iff (!reset_n_in)
      reg_wr_in && reg_addr_in >= pmirc_pkg::OFF_PRIO0_LIM &&
         reg_addr_in < pmirc_pkg::OFF_PRIO7_LIM |=>
         $stable(lim_active_q[0]) && $stable(lim_active_q[2]) && $stable(lim_active_q[3]);
   endproperty
   a_pending: assert property (p_pending) else $error("limit applied before commit"); // R12

   property p_commit;
      @(posedge mclk_in) disable iff (!reset_n_in)
      reg_wr_in && reg_addr_in == pmirc_pkg::OFF_PRIO7_LIM && !(reg_addr_in == 8'h10) |=>
         lim_active_q[0] == $past(lim_shadow_q[0]) && lim_active_q[7] == $past(reg_wdata_in[6:0]);
   endproperty
   a_commit: assert property (p_commit) else $error("commit did not apply limits"); // R12

   property p_cost;
      @(posedge mclk_in) disable iff (!reset_n_in)
      frame_valid_in && !pps_mode ##0 1'b1 |->
         cost == {1'b0, frame_in.len + (cnt_ifg ? 14'h00c : 14'h000)
            + (cnt_pre ? 14'h008 : 14'h000), 3'b000};
   endproperty
   a_cost: assert property (p_cost) else $error("bit cost wrong"); // R9

   property p_over_drop;
      @(posedge mclk_in) disable iff (!reset_n_in)
      frame_valid_in && exceed && !fc_use && !bad && !frame_in.is_fc_frame |=>
         verdict_out.drop && verdict_out.over_limit;
   endproperty
   a_over_drop: assert property (p_over_drop) else $error("excess frame admitted"); // R14

   property p_bcast_only;
      @(posedge mclk_in) disable iff (!reset_n_in)
      frame_valid_in && lim_mode == 2'h3 && !frame_in.is_bcast |=> !verdict_out.over_limit;
   endproperty
   a_bcast_only: assert property (p_bcast_only) else $error("uncounted frame limited"); // R8
endmodule

// ---- verif/pmirc_link_partner.sv ----
`timescale 1ns/10ps
// ============================================================
// link partner model
module pmirc_link_partner (
   input wire logic mclk_in,
   input wire logic send_in,
   input wire pmirc_pkg::pmirc_frame_s desc_in,
   input wire logic pause_req_in,
   output logic frame_valid_out,
   output pmirc_pkg::pmirc_frame_s frame_out,
   output logic [15:0] pause_cycles_out
);
   logic go;
   pmirc_pkg::pmirc_frame_s d;
   initial
   begin
      frame_valid_out = 1'b0;
      frame_out = '0;
      pause_cycles_out = 16'h0000;
   end
   // one descriptor per request; idle bus shows the inverse of the last value
   always @(posedge mclk_in)
   begin
      go = send_in;
      d = desc_in;
      #1;
      frame_valid_out = go;
      frame_out = go ? d : ~frame_out;
   end
   // count cycles in which the port asks us to pause
   always @(negedge mclk_in)
   begin
      if (pause_req_in === 1'b1)
         pause_cycles_out <= pause_cycles_out + 16'h0001;
   end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
// ============================================================
// bench top
module tb_top;
   localparam pmirc_pkg::pmirc_verdict_s V_FWD = 4'h8;
   localparam pmirc_pkg::pmirc_verdict_s V_MIR = 4'h4;
   localparam pmirc_pkg::pmirc_verdict_s V_DRP = 4'h2;
   localparam pmirc_pkg::pmirc_verdict_s V_OVR = 4'h3;
   localparam pmirc_pkg::pmirc_verdict_s V_FCO = 4'h9;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr_en = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic send = 1'b0;
   pmirc_pkg::pmirc_frame_s desc = '0;
   pmirc_pkg::pmirc_frame_s frame;
   logic frame_valid;
   logic verdict_valid;
   pmirc_pkg::pmirc_verdict_s verdict;
   logic fdx = 1'b1;
   logic phy = 1'b0;
   logic mac_fc = 1'b0;
   logic adv = 1'b0;
   logic filt = 1'b0;
   logic cong = 1'b0;
   logic pause_req;
   logic bp;
   logic [15:0] pcyc;
   logic [15:0] pc;
   logic [31:0] rng = 32'h0000f3db;
   logic [31:0] r;
   int err_count = 0;
   int checks = 0;
   pmirc_pkg::pmirc_verdict_s exp_q[$];
   bit skip_q[$];
   always #10 mclk_in = ~mclk_in;
   // design and far side
   pmirc_port #(.PPS_TICK_CYCLES(50)) uut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
      .reg_addr_in(addr), .reg_wr_in(wr_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .frame_valid_in(frame_valid), .frame_in(frame), .verdict_valid_out(verdict_valid),
      .verdict_out(verdict), .full_duplex_in(fdx), .phy_port_in(phy), .mac_rx_fc_en_in(mac_fc),
      .phy_pause_adv_in(adv), .fc_frame_filter_in(filt), .fabric_congested_in(cong),
      .pause_req_out(pause_req), .backpressure_out(bp));
   pmirc_link_partner partner (.mclk_in(mclk_in), .send_in(send), .desc_in(desc),
      .pause_req_in(pause_req), .frame_valid_out(frame_valid), .frame_out(frame),
      .pause_cycles_out(pcyc));
   // ============================================================
   // helpers
   function automatic logic [31:0] next_rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic pmirc_pkg::pmirc_frame_s mk(input int t, input logic [2:0] p,
      input logic [13:0] len);
      pmirc_pkg::pmirc_frame_s f;
      f = '0;
      f.len = (len == 14'h0000) ? 14'(64 + next_rnd() % 1455) : len;
      f.prio = p;
      f.is_flood = (t == 1);
      f.is_mcast = (t == 2);
      f.is_bcast = (t == 3);
      f.crc_err = (t == 4);
      f.len_err = (t == 5);
      f.is_fc_frame = (t == 6);
      return f;
   endfunction
   task automatic fail(input string msg);
      err_count++;
      $display("Error at %0t: %s", $time, msg);
   endtask
   task automatic complete_run();
      if (err_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] e);
      checks++;
      if (got !== e)
         fail($sformatf("read %h expected %h", got, e));
   endtask
   task automatic cmp_bit(input logic got, input logic e);
      checks++;
      if (got !== e)
         fail($sformatf("level %b expected %b", got, e));
   endtask
   task automatic cmp_verdict(input pmirc_pkg::pmirc_verdict_s got,
      input pmirc_pkg::pmirc_verdict_s e);
      checks++;
      if (got !== e)
         fail($sformatf("verdict %h expected %h", got, e));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      cyc(1);
      wr_en = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      cyc(1);
      cmp_byte(rdata, e);
   endtask
   task automatic snd(input pmirc_pkg::pmirc_frame_s f, input pmirc_pkg::pmirc_verdict_s e,
      input bit skip);
      desc = f;
      send = 1'b1;
      exp_q.push_back(e);
      skip_q.push_back(skip);
      cyc(1);
   endtask
   task automatic idle(input int n);
      int k;
      send = 1'b0;
      k = 0;
      cyc(n);
      while (exp_q.size() != 0 && k < 20)
      begin
         cyc(1);
         k++;
      end
      if (exp_q.size() != 0)
      begin
         fail("verdict missing");
         complete_run();
      end
   endtask
   task automatic do_reset();
      reset_n_in = 1'b0;
      cyc(3);
      reset_n_in = 1'b1;
      cyc(1);
   endtask
   // ============================================================
   // verdict monitor: oldest note against each answer
   always @(negedge mclk_in)
   begin
      if (verdict_valid === 1'b1 && exp_q.size() == 0)
         fail("verdict without frame");
      else if (verdict_valid === 1'b1 && skip_q.pop_front() == 1'b0)
         cmp_verdict(verdict, exp_q.pop_front());
      else if (verdict_valid === 1'b1)
         void'(exp_q.pop_front());
   end
   // watchdog
   initial
   begin
      repeat (20000) @(posedge mclk_in);
      fail("timeout");
      complete_run();
   end
   // ============================================================
   // main sequence
   initial
   begin
      do_reset();
      // reset values, read-only bits, unmapped place
      rd(8'h01, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h10, 8'h00);
      r = next_rnd();
      wr(8'h01, r[7:0]);
      rd(8'h01, r[7:0] & 8'hbf);
      wr(8'h03, r[15:8]);
      rd(8'h03, r[15:8] & 8'h7f);
      wr(8'h12, r[23:16]);
      rd(8'h12, r[23:16] & 8'h7f);
      wr(8'h05, 8'hff);
      rd(8'h05, 8'h00);
      do_reset();
      // bad frames and flow-control frame filtering
      snd(mk(4, 3'h0, 14'h0000), V_DRP, 1'b0);
      snd(mk(5, 3'h0, 14'h0000), V_DRP, 1'b0);
      idle(1);
      wr(8'h01, 8'h01);
      filt = 1'b1;
      snd(mk(4, 3'h0, 14'h0000), V_MIR, 1'b0);
      snd(mk(5, 3'h0, 14'h0000), V_MIR, 1'b0);
      snd(mk(6, 3'h0, 14'h0000), V_DRP, 1'b0);
      idle(1);
      filt = 1'b0;
      snd(mk(6, 3'h0, 14'h0000), V_FWD, 1'b0);
      idle(1);
      wr(8'h01, 8'h00);
      // pending limit, commit, frame classes, granularity
      wr(8'h10, 8'h01);
      snd(mk(3, 3'h0, 14'h0000), V_FWD, 1'b0);
      idle(1);
      wr(8'h17, 8'h00);
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h03, 8'(m << 2));
         for (int t = 0; t < 4; t++)
            snd(mk(t, 3'h0, 14'h0000), (t >= m) ? V_OVR : V_FWD, 1'b0);
         idle(1);
      end
      wr(8'h03, 8'h00);
      snd(mk(0, 3'h1, 14'h0000), V_FWD, 1'b0);
      idle(1);
      wr(8'h03, 8'h40);
      snd(mk(0, 3'h1, 14'h0000), V_OVR, 1'b0);
      idle(1);
      // flow control on overrun and its gates
      wr(8'h03, 8'h50);
      snd(mk(0, 3'h0, 14'h0000), V_OVR, 1'b0);
      idle(3);
      cmp_bit(|pcyc, 1'b0);
      mac_fc = 1'b1;
      snd(mk(0, 3'h0, 14'h0000), V_FCO, 1'b0);
      idle(3);
      cmp_bit(|pcyc, 1'b1);
      phy = 1'b1;
      idle(60);
      pc = pcyc;
      snd(mk(0, 3'h0, 14'h0000), V_OVR, 1'b0);
      idle(3);
      cmp_bit(|(pcyc ^ pc), 1'b0);
      adv = 1'b1;
      snd(mk(0, 3'h0, 14'h0000), V_FCO, 1'b0);
      idle(3);
      cmp_bit(|(pcyc ^ pc), 1'b1);
      wr(8'h03, 8'h40);
      snd(mk(0, 3'h0, 14'h0000), V_OVR, 1'b0);
      idle(1);
      // back pressure only in half duplex
      wr(8'h01, 8'h08);
      cong = 1'b1;
      fdx = 1'b0;
      cyc(1);
      cmp_bit(bp, 1'b1);
      fdx = 1'b1;
      cyc(1);
      cmp_bit(bp, 1'b0);
      fdx = 1'b0;
      wr(8'h01, 8'h00);
      cmp_bit(bp, 1'b0);
      cong = 1'b0;
      fdx = 1'b1;
      // gap and preamble bytes: 10 bits per 50 cycles, credit 200 against costs 224 and 160
      do_reset();
      wr(8'h03, 8'h43);
      wr(8'h10, 8'h0a);
      wr(8'h17, 8'h00);
      idle(1010);
      snd(mk(0, 3'h0, 14'h0008), V_OVR, 1'b0);
      idle(1);
      wr(8'h03, 8'h42);
      snd(mk(0, 3'h0, 14'h0008), V_FWD, 1'b0);
      idle(1);
      // packet counting: 5 ticks of credit before the burst, preamble ignored
      do_reset();
      wr(8'h03, 8'h63);
      wr(8'h10, 8'h01);
      wr(8'h17, 8'h00);
      idle(260);
      for (int i = 0; i < 8; i++)
         snd(mk(0, 3'h0, 14'h0000), (i < 5) ? V_FWD : V_OVR, 1'b0);
      idle(1);
      complete_run();
   end
endmodule
